// file: ucg_top.sv
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module ucg_top
(
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               clk_en,
	// AXI4-Lite slave
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// Pins and event inputs
	input  wire logic               role_id_pin,
	input  wire logic               vbus_level,
	input  wire logic [ucg_pkg::NUM_IRQ-1:0] usb_event,
	input  wire logic               bus_reset_end,
	input  wire logic               hs_negotiated,
	input  wire logic               cpu_power_down,
	// Controller outputs
	output logic                    usb_irq,
	output logic                    cpu_wake,
	output logic                    macro_enable,
	output logic                    pad_suspend,
	output logic                    clocks_enable,
	output logic                    host_active,
	output logic                    device_active,
	output logic                    pulldown_en,
	output logic                    hs_term_en,
	output logic                    fs_pad_sel
);
	import ucg_pkg::*;

	// ------------------------------------------------------------
	// Storage and state
	// ------------------------------------------------------------
	logic [7:0]         ram_q [RAM_BYTES];
	ucg_state_t         st_q, st_d;
	logic               en_q, en_d, host_sel_q, host_sel_d, frz_q, frz_d;
	logic               dsel_q, dsel_d;
	logic [ADDR_W-1:0]  daddr_q, daddr_d;
	logic [1:0]         spd_q, spd_d;
	logic [NUM_IRQ-1:0] irq_q, irq_d, ien_q, ien_d;
	logic               id_q, id_d, vbus_q, vbus_d, hs_q, hs_d;
	logic               aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d, ar_q;
	logic [7:0]         awa_q, awa_d;
	logic [31:0]        wd_q, wd_d, rd_q, rd_d;
	logic [3:0]         ws_q, ws_d;
	logic [1:0]         br_q, br_d, rr_q, rr_d;
	logic               ram_we;
	logic [7:0]         ram_wdat;
	logic               irq_o_d, wake_d;
	logic [NUM_IRQ-1:0] ev;
	logic               do_wr, do_rd, fifo_wr, fifo_rd;
	logic               awrdy_q, wrdy_q, arrdy_q;

	// ------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------
	// One write and one read in flight; address and data in any order
	always_comb begin
		aw_d  = aw_q;
		w_d   = w_q;
		b_d   = b_q;
		awa_d = awa_q;
		wd_d  = wd_q;
		ws_d  = ws_q;
		if (s_axi_awvalid && !aw_q && !b_q) begin
			aw_d  = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_q && !b_q) begin
			w_d  = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		do_wr = aw_q && w_q && !b_q;
		if (do_wr) begin
			aw_d = 1'b0;
			w_d  = 1'b0;
			b_d  = 1'b1;
		end else if (b_q && s_axi_bready) begin
			b_d = 1'b0;
		end
		do_rd = s_axi_arvalid && !r_q && !ar_q;
		r_d   = r_q;
		if (do_rd)
			r_d = 1'b1;
		else if (r_q && s_axi_rready)
			r_d = 1'b0;
	end

	assign fifo_wr = do_wr && awa_q == FIFO_DATA_OFS && dsel_q && ws_q[0];
	assign fifo_rd = do_rd && s_axi_araddr == FIFO_DATA_OFS && dsel_q;
	assign ram_we   = fifo_wr && clk_en;
	assign ram_wdat = wd_q[7:0];

	// ------------------------------------------------------------
	// Controller state and registers
	// ------------------------------------------------------------
	// Freeze gates ordinary events; wake, ID and VBUS still pass
	always_comb begin
		ev = usb_event;
		ev[IRQ_ID]   = usb_event[IRQ_ID] | (id_q != role_id_pin);
		ev[IRQ_VBUS] = usb_event[IRQ_VBUS] | (vbus_q != vbus_level);
		if (frz_q) begin
			ev = '0;
			ev[IRQ_WAKE] = usb_event[IRQ_WAKE];
			ev[IRQ_ID]   = usb_event[IRQ_ID] | (id_q != role_id_pin);
			ev[IRQ_VBUS] = usb_event[IRQ_VBUS] | (vbus_q != vbus_level);
		end
		if (!en_q) begin
			// ID change still reported with controller off
			ev[IRQ_SRP]  = 1'b0;
			ev[IRQ_ROLE] = 1'b0;
			ev[IRQ_VDROP] = 1'b0;
			ev[IRQ_BCERR] = 1'b0;
			ev[IRQ_HNPERR] = 1'b0;
			ev[IRQ_STO]  = 1'b0;
			ev[IRQ_RSM]  = 1'b0;
		end
	end

	always_comb begin
		en_d       = en_q;
		host_sel_d = host_sel_q;
		frz_d      = frz_q;
		dsel_d     = dsel_q;
		daddr_d    = daddr_q;
		spd_d      = spd_q;
		ien_d      = ien_q;
		irq_d      = irq_q;
		id_d       = role_id_pin;
		vbus_d     = vbus_level;
		hs_d       = hs_q;
		st_d       = st_q;
		// Software clear first so a same-cycle event wins
		if (do_wr && awa_q == GEN_IRQ_OFS && ws_q[0])
			irq_d = irq_q & ~wd_q[NUM_IRQ-1:0];
		irq_d = irq_d | ev;
		if (do_wr) begin
			unique case (awa_q)
				GEN_CTRL_OFS: if (ws_q[0]) begin
					en_d       = wd_q[CTRL_EN_BIT];
					host_sel_d = wd_q[CTRL_HOST_BIT];
					frz_d      = wd_q[CTRL_FRZ_BIT];
				end
				GEN_IEN_OFS: if (ws_q[0])
					ien_d = wd_q[NUM_IRQ-1:0];
				// Writable even with the controller off
				DADDR_OFS: begin
					if (ws_q[0])
						daddr_d[7:0] = wd_q[7:0];
					if (ws_q[1])
						daddr_d[ADDR_W-1:8] = wd_q[ADDR_W-1:8];
					if (ws_q[2])
						dsel_d = wd_q[DADDR_SEL_BIT];
				end
				SPEED_OFS: if (ws_q[0])
					spd_d = wd_q[1:0];
				default: ;
			endcase
		end
		// Direct FIFO access walks the address; the 11-bit field cannot
		// reach the RAM end, so it wraps only at its own top
		if (fifo_wr || fifo_rd) begin
			if (32'(daddr_q) >= 32'(RAM_BYTES - 1))
				daddr_d = '0;
			else
				daddr_d = daddr_q + 11'h001;
		end
		unique case (st_q)
			ST_RESET: begin
				hs_d = 1'b0;
				if (en_q)
					st_d = role_id_pin ? ST_DEVICE : ST_HOST;
			end
			ST_DEVICE: begin
				if (bus_reset_end)
					hs_d = hs_negotiated && spd_q != SPD_FS_FSPAD
						&& spd_q != SPD_FS_HSPAD;
				if (!role_id_pin)
					st_d = ST_HOST;
			end
			ST_HOST: begin
				hs_d = 1'b0;
				if (role_id_pin)
					st_d = ST_DEVICE;
			end
			default: st_d = ST_RESET;
		endcase
		// Disable acts as reset; speed returns to default
		if (!en_q) begin
			st_d  = ST_RESET;
			spd_d = (do_wr && awa_q == SPEED_OFS && ws_q[0]) ?
				wd_q[1:0] : spd_d;
			hs_d  = 1'b0;
		end
		if (en_q && do_wr && awa_q == GEN_CTRL_OFS && ws_q[0]
			&& !wd_q[CTRL_EN_BIT]) begin
			spd_d = SPEED_RST;
			frz_d = FRZ_RST;
		end
	end

	// Interrupt request and CPU wake
	always_comb begin
		irq_o_d = |(irq_q & ien_q);
		if (cpu_power_down) begin
			wake_d = (irq_q[IRQ_ID] & ien_q[IRQ_ID])
				| (irq_q[IRQ_VBUS] & ien_q[IRQ_VBUS]);
			if (host_sel_q)
				wake_d = wake_d | (irq_q[IRQ_RSM] & ien_q[IRQ_RSM])
					| (irq_q[IRQ_SRP] & ien_q[IRQ_SRP]);
			else
				wake_d = wake_d | (irq_q[IRQ_WAKE] & ien_q[IRQ_WAKE]);
		end else begin
			wake_d = irq_o_d;
		end
	end

	// Read data mux; registers readable while frozen
	always_comb begin
		rd_d = rd_q;
		rr_d = rr_q;
		br_d = br_q;
		if (do_wr)
			br_d = 2'b00;
		if (do_rd) begin
			rr_d = 2'b00;
			unique case (s_axi_araddr)
				GEN_CTRL_OFS: rd_d = 32'({en_q, host_sel_q, frz_q, 5'h00});
				GEN_STAT_OFS: rd_d = 32'({hs_q, vbus_level,
					role_id_pin, st_q});
				GEN_IRQ_OFS:  rd_d = 32'(irq_q);
				GEN_IEN_OFS:  rd_d = 32'(ien_q);
				DADDR_OFS:    rd_d = 32'({dsel_q, 5'h00, daddr_q});
				FIFO_DATA_OFS: rd_d = dsel_q ? 32'(ram_q[daddr_q]) : '0;
				SPEED_OFS:    rd_d = 32'(spd_q);
				// Bank choice follows host-select, not detected role
				DEV_IRQ_OFS, HOST_IRQ_OFS:
					rd_d = 32'(host_sel_q);
				default: begin
					rd_d = '0;
					rr_d = 2'b10;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q       <= ST_RESET;
			en_q       <= 1'b0;
			host_sel_q <= 1'b0;
			frz_q      <= FRZ_RST;
			dsel_q     <= 1'b0;
			daddr_q    <= '0;
			spd_q      <= SPEED_RST;
			irq_q      <= '0;
			ien_q      <= '0;
			id_q       <= 1'b1;
			vbus_q     <= 1'b0;
			hs_q       <= 1'b0;
			aw_q       <= 1'b0;
			w_q        <= 1'b0;
			b_q        <= 1'b0;
			r_q        <= 1'b0;
			ar_q       <= 1'b0;
			awa_q      <= '0;
			wd_q       <= '0;
			ws_q       <= '0;
			rd_q       <= '0;
			br_q       <= '0;
			rr_q       <= '0;
			usb_irq    <= 1'b0;
			cpu_wake   <= 1'b0;
			awrdy_q    <= 1'b1;
			wrdy_q     <= 1'b1;
			arrdy_q    <= 1'b1;
		end else if (clk_en) begin
			st_q       <= st_d;
			en_q       <= en_d;
			host_sel_q <= host_sel_d;
			frz_q      <= frz_d;
			dsel_q     <= dsel_d;
			daddr_q    <= daddr_d;
			spd_q      <= spd_d;
			irq_q      <= irq_d;
			ien_q      <= ien_d;
			id_q       <= id_d;
			vbus_q     <= vbus_d;
			hs_q       <= hs_d;
			aw_q       <= aw_d;
			w_q        <= w_d;
			b_q        <= b_d;
			r_q        <= r_d;
			ar_q       <= do_rd;
			awa_q      <= awa_d;
			wd_q       <= wd_d;
			ws_q       <= ws_d;
			rd_q       <= rd_d;
			br_q       <= br_d;
			rr_q       <= rr_d;
			usb_irq    <= irq_o_d;
			cpu_wake   <= wake_d;
			awrdy_q    <= !aw_d && !b_d;
			wrdy_q     <= !w_d && !b_d;
			arrdy_q    <= !r_d && !do_rd;
		end
	end

	// RAM keeps contents over reset; no reset term on purpose
	always_ff @(posedge aclk) begin
		if (ram_we)
			ram_q[daddr_q] <= ram_wdat;
	end

	// Pad and macro controls registered from the next-state values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			macro_enable  <= 1'b0;
			pad_suspend   <= 1'b1;
			clocks_enable <= 1'b0;
			host_active   <= 1'b0;
			device_active <= 1'b0;
			pulldown_en   <= 1'b0;
			hs_term_en    <= 1'b0;
			fs_pad_sel    <= 1'b0;
		end else if (clk_en) begin
			macro_enable  <= en_d;
			pad_suspend   <= !en_d;
			clocks_enable <= en_d && !frz_d;
			host_active   <= st_d == ST_HOST;
			device_active <= st_d == ST_DEVICE;
			pulldown_en   <= st_d == ST_HOST;
			hs_term_en    <= hs_d && st_d == ST_DEVICE;
			fs_pad_sel    <= st_d == ST_HOST
				|| spd_d == SPD_FS_FSPAD;
		end
	end

	assign s_axi_awready = awrdy_q;
	assign s_axi_wready  = wrdy_q;
	assign s_axi_bvalid  = b_q;
	assign s_axi_bresp   = br_q;
	assign s_axi_arready = arrdy_q;
	assign s_axi_rvalid  = r_q;
	assign s_axi_rdata   = rd_q;
	assign s_axi_rresp   = rr_q;

endmodule : ucg_top
`default_nettype wire

// file: ucg_pkg.sv
package ucg_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam logic [7:0] GEN_CTRL_OFS   = 8'h00;
	localparam logic [7:0] GEN_STAT_OFS   = 8'h04;
	localparam logic [7:0] GEN_IRQ_OFS    = 8'h08;
	localparam logic [7:0] GEN_IEN_OFS    = 8'h0C;
	localparam logic [7:0] DADDR_OFS      = 8'h10;
	localparam logic [7:0] FIFO_DATA_OFS  = 8'h14;
	localparam logic [7:0] SPEED_OFS      = 8'h18;
	localparam logic [7:0] DEV_IRQ_OFS    = 8'h1C;
	localparam logic [7:0] HOST_IRQ_OFS   = 8'h20;

	// ------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------
	localparam int CTRL_EN_BIT    = 7;
	localparam int CTRL_HOST_BIT  = 6;
	localparam int CTRL_FRZ_BIT   = 5;
	localparam int DADDR_SEL_BIT  = 16;

	// General/OTG flag positions in the irq word
	localparam int IRQ_ID      = 0;
	localparam int IRQ_VBUS    = 1;
	localparam int IRQ_SRP     = 2;
	localparam int IRQ_ROLE    = 3;
	localparam int IRQ_VDROP   = 4;
	localparam int IRQ_BCERR   = 5;
	localparam int IRQ_HNPERR  = 6;
	localparam int IRQ_STO     = 7;
	localparam int IRQ_WAKE    = 8;
	localparam int IRQ_RSM     = 9;
	localparam int NUM_IRQ     = 10;

	// ------------------------------------------------------------
	// Sizes and reset values
	// ------------------------------------------------------------
	localparam int RAM_BYTES = 2368;
	localparam int ADDR_W    = 11;
	localparam logic [1:0] SPEED_RST  = 2'h0;
	localparam logic       FRZ_RST    = 1'b1;

	// Speed-force encodings
	localparam logic [1:0] SPD_NORMAL  = 2'h0;
	localparam logic [1:0] SPD_FS_FSPAD = 2'h1;
	localparam logic [1:0] SPD_HS_ONLY = 2'h2;
	localparam logic [1:0] SPD_FS_HSPAD = 2'h3;

	// Controller states
	typedef enum logic [1:0] {
		ST_RESET  = 2'b00,
		ST_DEVICE = 2'b01,
		ST_HOST   = 2'b10
	} ucg_state_t;

endpackage : ucg_pkg

// file: ucg_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ------
// Port checker for the general operating logic
// ------
module ucg_properties (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        clk_en,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        role_id_pin,
	input wire logic        cpu_power_down,
	input wire logic        usb_irq,
	input wire logic        cpu_wake,
	input wire logic        macro_enable,
	input wire logic        pad_suspend,
	input wire logic        clocks_enable,
	input wire logic        host_active,
	input wire logic        device_active,
	input wire logic        pulldown_en
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_rst;
		$rose(aresetn) |-> !macro_enable && pad_suspend && !clocks_enable
			&& !usb_irq && !host_active && !device_active;
	endproperty
	a_rst: assert property (p_rst)
		else $error("controller active right after reset");

	property p_pad;
		pad_suspend != macro_enable;
	endproperty
	a_pad: assert property (p_pad)
		else $error("pad suspend not inverse of enable");

	property p_clk;
		clocks_enable |-> macro_enable;
	endproperty
	a_clk: assert property (p_clk)
		else $error("clocks on while disabled");

	// Roles may trail the enable by one register stage
	property p_off;
		$fell(macro_enable) |-> ##[0:1] !(host_active || device_active);
	endproperty
	a_off: assert property (p_off)
		else $error("role kept after disable");

	property p_host;
		(macro_enable && !role_id_pin)[*3] |-> host_active && pulldown_en;
	endproperty
	a_host: assert property (p_host)
		else $error("host role or pull-downs missing");

	property p_dev;
		(macro_enable && role_id_pin)[*3] |-> device_active && !pulldown_en;
	endproperty
	a_dev: assert property (p_dev)
		else $error("device role missing");

	// Only a flag clear or enable write may drop the request
	property p_irq;
		(!s_axi_wvalid)[*4] ##0 usb_irq |=> usb_irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request dropped alone");

	property p_wake;
		usb_irq && !cpu_power_down |-> ##[0:1] cpu_wake;
	endproperty
	a_wake: assert property (p_wake)
		else $error("pending interrupt did not wake");

	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold)
		else $error("read answer not held");

	property p_rlat;
		s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid;
	endproperty
	a_rlat: assert property (p_rlat)
		else $error("read answer late");
endmodule : ucg_properties

bind ucg_top ucg_properties u_chk (.aclk, .aresetn, .clk_en, .s_axi_wvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.role_id_pin, .cpu_power_down, .usb_irq, .cpu_wake, .macro_enable,
	.pad_suspend, .clocks_enable, .host_active, .device_active, .pulldown_en);
`default_nettype wire

// file: ucg_far.sv
`timescale 1ns/10ps
`default_nettype none
// ------
// Far-side USB party: plug, cable events, bus reset
// ------
module ucg_far (
	input  wire logic                   aclk,
	output logic                        role_id_pin,
	output logic                        vbus_level,
	output logic [ucg_pkg::NUM_IRQ-1:0] usb_event,
	output logic                        bus_reset_end,
	output logic                        hs_negotiated
);
	import ucg_pkg::*;

	// Idle cable: nothing on ID, so the pull-up reads high
	initial begin
		role_id_pin   = 1'b1;
		vbus_level    = 1'b0;
		usb_event     = '0;
		bus_reset_end = 1'b0;
		hs_negotiated = 1'b0;
	end

	// One-cycle event strobe; a VBUS event also moves the level
	task automatic fire(input int i);
		@(posedge aclk);
		usb_event <= NUM_IRQ'(1 << i);
		if (i == IRQ_VBUS)
			vbus_level <= !vbus_level;
		@(posedge aclk);
		usb_event <= '0;
	endtask : fire

	// End of bus reset with the chirp outcome
	task automatic bus_reset(input logic hs);
		@(posedge aclk);
		hs_negotiated <= hs;
		bus_reset_end <= 1'b1;
		@(posedge aclk);
		bus_reset_end <= 1'b0;
	endtask : bus_reset

	// A-plug inserted pulls ID low
	task automatic plug(input logic id);
		@(posedge aclk);
		role_id_pin <= id;
	endtask : plug
endmodule : ucg_far
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end
// ------
// Bench
// ------
module tb_top;
	import ucg_pkg::*;
	logic        aclk, aresetn, clk_en, cpu_power_down;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, b0, b1;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, role_id_pin, vbus_level;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        bus_reset_end, hs_negotiated, usb_irq, cpu_wake;
	logic        macro_enable, pad_suspend, clocks_enable, host_active;
	logic        device_active, pulldown_en, hs_term_en, fs_pad_sel;
	logic [NUM_IRQ-1:0] usb_event;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	int          n_fail, checked, cyc;
	int          pd_ev[6] = '{8, 9, 2, 2, 8, 0};
	logic [5:0]  pd_x = 6'h36;

	ucg_top uut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.role_id_pin, .vbus_level, .usb_event, .bus_reset_end, .hs_negotiated,
		.cpu_power_down, .usb_irq, .cpu_wake, .macro_enable, .pad_suspend,
		.clocks_enable, .host_active, .device_active, .pulldown_en, .hs_term_en,
		.fs_pad_sel);
	ucg_far u_far (.aclk, .role_id_pin, .vbus_level, .usb_event, .bus_reset_end,
		.hs_negotiated);

	// 25 MHz clock
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic close_out;
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 8000) begin
			n_fail++;
			close_out;
		end
	end

	// Answers are matched in issue order, one transfer at a time
	always @(posedge aclk) begin
		if (aresetn && s_axi_rvalid && s_axi_rready) begin
			e = exp_q.pop_front();
			`CHK("read word", e, {s_axi_rresp, s_axi_rdata})
		end
		if (aresetn && s_axi_bvalid && s_axi_bready) begin
			e = exp_q.pop_front();
			`CHK("write resp", e[33:32], s_axi_bresp)
		end
	end

	// Write: both halves offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		exp_q.push_back(34'h0);
		while (!(aw && w)) begin
			@(posedge aclk);
			if (s_axi_awready && !aw) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !w) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask : wr

	// Read: rready comes a cycle late so the answer must stand
	task automatic rd(input logic [7:0] a, input logic [33:0] x);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		exp_q.push_back(x);
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic ev(input int i);
		u_far.fire(i);
		repeat (3) @(posedge aclk);
	endtask : ev

	// Main sequence
	initial begin
		void'($urandom(83));
		aresetn = 1'b0;
		clk_en = 1'b1;
		cpu_power_down = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		`CHK("enable out", 1'b0, macro_enable)
		`CHK("pad suspend", 1'b1, pad_suspend)
		rd(GEN_CTRL_OFS, 34'h20);
		rd(SPEED_OFS, 34'h0);
		rd(8'hFC, {2'h2, 32'h0});
		wr(8'hFC, 32'hFFFFFFFF);
		// Direct RAM access while disabled, across the top address
		b0 = 8'($urandom);
		b1 = 8'($urandom);
		wr(SPEED_OFS, 32'h1);
		rd(SPEED_OFS, 34'h1);
		wr(DADDR_OFS, 32'h000107FE);
		wr(FIFO_DATA_OFS, {24'h0, b0});
		wr(FIFO_DATA_OFS, {24'h0, b1});
		rd(DADDR_OFS, 34'h00010000);
		wr(DADDR_OFS, 32'h000107FE);
		rd(FIFO_DATA_OFS, {26'h0, b0});
		rd(FIFO_DATA_OFS, {26'h0, b1});
		wr(DADDR_OFS, 32'h0);
		// Every speed code in device mode
		for (int s = 0; s < 4; s++) begin
			wr(SPEED_OFS, 32'(s));
			wr(GEN_CTRL_OFS, 32'h80);
			u_far.bus_reset(1'b1);
			repeat (3) @(posedge aclk);
			`CHK("hs term", 1'(s == 0 || s == 2), hs_term_en)
			`CHK("fs pad", 1'(s == 1), fs_pad_sel)
			`CHK("device", 1'b1, device_active)
			`CHK("clocks", 1'b1, clocks_enable)
			wr(GEN_CTRL_OFS, 32'h0);
			rd(SPEED_OFS, 34'h0);
		end
		rd(GEN_CTRL_OFS, 34'h20);
		// Host role, then each flag raised, held and cleared; SRP masked
		wr(GEN_IEN_OFS, 32'h3FF);
		wr(GEN_CTRL_OFS, 32'hC0);
		u_far.plug(1'b0);
		repeat (3) @(posedge aclk);
		`CHK("host", 1'b1, host_active)
		`CHK("device off", 1'b0, device_active)
		`CHK("pulldown", 1'b1, pulldown_en)
		`CHK("host pad", 1'b1, fs_pad_sel)
		for (int i = 0; i < NUM_IRQ; i++) begin
			wr(GEN_IRQ_OFS, 32'h3FF);
			ev(i);
			rd(GEN_IRQ_OFS, 34'(1 << i));
			`CHK("irq line", 1'b1, usb_irq)
			`CHK("idle wake", 1'b1, cpu_wake)
		end
		wr(GEN_IRQ_OFS, 32'h3FF);
		wr(GEN_IEN_OFS, 32'h0);
		ev(IRQ_SRP);
		`CHK("masked line", 1'b0, usb_irq)
		wr(GEN_IEN_OFS, 32'h3FF);
		`CHK("unmasked line", 1'b1, usb_irq)
		// Wake sources in power-down by host select
		cpu_power_down <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			wr(GEN_CTRL_OFS, k < 3 ? 32'hC0 : 32'h80);
			wr(GEN_IRQ_OFS, 32'h3FF);
			ev(pd_ev[k]);
			`CHK("pd wake", pd_x[k], cpu_wake)
		end
		cpu_power_down <= 1'b0;
		// Frozen clock passes only three sources
		wr(GEN_CTRL_OFS, 32'hA0);
		wr(GEN_IRQ_OFS, 32'h3FF);
		for (int i = 0; i < NUM_IRQ; i++)
			ev(i);
		rd(GEN_IRQ_OFS, 34'h103);
		`CHK("frozen clocks", 1'b0, clocks_enable)
		rd(GEN_CTRL_OFS, 34'hA0);
		// Clock enable low: an event meanwhile must leave no trace
		wr(GEN_IRQ_OFS, 32'h3FF);
		clk_en <= 1'b0;
		ev(IRQ_WAKE);
		clk_en <= 1'b1;
		rd(GEN_IRQ_OFS, 34'h0);
		// Disable while in host role
		wr(GEN_CTRL_OFS, 32'h0);
		`CHK("host off", 1'b0, host_active)
		`CHK("macro off", 1'b0, macro_enable)
		`CHK("pulldown off", 1'b0, pulldown_en)
		// Reset in mid-run: registers back to reset, RAM contents kept
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(GEN_CTRL_OFS, 34'h20);
		wr(DADDR_OFS, 32'h000107FE);
		rd(FIFO_DATA_OFS, {26'h0, b0});
		close_out;
	end
endmodule : tb_top
`default_nettype wire
